// file: design/cpulb_lane_steer.sv
// Purpose: Bus unit addressing, cycle status and byte-lane steering
// Assumes: One request at a time from the internal units; ready is
//          an active-low pin sampled through a three-stage synchroniser
// Notes:   Data pins pass the same synchroniser depth as ready, so a
//          captured word is aligned with the ready that qualifies it
`timescale 1ns/1ps

module cpulb_lane_steer
    import cpulb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic protected_mode,
    input wire cpulb_req_t req,
    output logic req_ready,
    output cpulb_ans_t ans,
    output logic [23:0] addr_out,
    output logic upper_lane_enable_n,
    output cpulb_stat_t stat_out,
    output logic [15:0] data_out,
    output logic [1:0] data_oe,
    input wire logic [15:0] data_in,
    input wire logic bus_ready_n,
    input wire logic nmi_pin,
    input wire logic maskable_request,
    input wire logic int_enable,
    input wire logic iret_done,
    output logic nmi_take,
    output logic maskable_take,
    output logic [7:0] int_vector,
    output logic [23:0] vector_ptr
);

    // ****************************************************************
    // Pin synchronisers: data, ready, nmi, maskable request
    // ****************************************************************
    localparam int PIN_W = 19;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] stage1_reg, s2_reg, s3_reg, filt_reg;
    logic [PIN_W-1:0] filt_next;

    assign pin_raw = {maskable_request, nmi_pin, bus_ready_n, data_in};

    // A level only counts once the last two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            always_comb begin
                filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi]
                                                          : filt_reg[gi];
            end
        end
    endgenerate

    // Sync ready resets inactive (high), other pins low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= 19'h1_0000;
            s2_reg <= 19'h1_0000;
            s3_reg <= 19'h1_0000;
            filt_reg <= 19'h1_0000;
        end else begin
            stage1_reg <= pin_raw;
            s2_reg <= stage1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    logic [15:0] lane_data;
    logic ready_seen;
    logic nmi_lvl, irq_lvl;
    assign lane_data = filt_reg[15:0];
    assign ready_seen = ~filt_reg[16];
    assign nmi_lvl = filt_reg[17];
    assign irq_lvl = filt_reg[18];

    // ****************************************************************
    // Bus cycle sequencer
    // ****************************************************************
    cpulb_state_t state_reg, state_next;
    logic [23:0] addr_reg, addr_next;
    logic hi_en_n_reg, hi_en_n_next;
    logic [3:0] stat_reg, stat_next;
    logic [3:0] cyc_stat_reg, cyc_stat_next;
    logic [15:0] dout_reg, dout_next;
    logic [1:0] oe_reg, oe_next;
    logic split_reg, split_next;
    logic second_reg, second_next;
    logic wr_reg, wr_next;
    logic odd_fetch_reg, odd_fetch_next;
    logic [7:0] hi_byte_reg, hi_byte_next;
    logic ack_cyc_reg, ack_cyc_next;
    cpulb_ans_t ans_reg, ans_next;
    logic [23:0] mapped;
    logic [3:0] code;
    logic is_wr, is_word;

    assign req_ready = (state_reg == ST_IDLE);

    // Status code and address map of the incoming request
    always_comb begin
        mapped = req.addr & (protected_mode ? PROT_ADDR_MASK
                                            : REAL_ADDR_MASK);
        is_wr = 1'b0;
        is_word = req.word;
        case (req.kind)
            CYC_MEM_RD: code = STAT_MEM_RD;
            CYC_IO_RD: begin
                code = STAT_IO_RD;
                mapped = req.addr & IO_ADDR_MASK;
            end
            CYC_FETCH: begin
                code = STAT_FETCH;
                is_word = 1'b1;
            end
            CYC_MEM_WR: begin
                code = STAT_MEM_WR;
                is_wr = 1'b1;
            end
            CYC_IO_WR: begin
                code = STAT_IO_WR;
                is_wr = 1'b1;
                mapped = req.addr & IO_ADDR_MASK;
            end
            CYC_INT_ACK: begin
                code = STAT_INT_ACK;
                is_word = 1'b0;
                mapped = SHUTDOWN_ADDR;
            end
            CYC_HALT: begin
                code = STAT_HALT;
                is_word = 1'b0;
                mapped = HALT_ADDR;
            end
            CYC_SHUTDOWN: begin
                code = STAT_HALT;
                is_word = 1'b0;
                mapped = SHUTDOWN_ADDR;
            end
            default: code = STAT_PASSIVE;
        endcase
    end

    // Next-state logic for the sequencer and lane steering
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        hi_en_n_next = hi_en_n_reg;
        stat_next = STAT_PASSIVE;
        cyc_stat_next = cyc_stat_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        split_next = split_reg;
        second_next = second_reg;
        wr_next = wr_reg;
        odd_fetch_next = odd_fetch_reg;
        hi_byte_next = hi_byte_reg;
        ack_cyc_next = ack_cyc_reg;
        ans_next = ans_reg;
        ans_next.done = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (req.valid) begin
                    state_next = ST_STATUS;
                    stat_next = code;
                    cyc_stat_next = code;
                    wr_next = is_wr;
                    second_next = 1'b0;
                    ack_cyc_next = (req.kind == CYC_INT_ACK);
                    odd_fetch_next = (req.kind == CYC_FETCH) & mapped[0];
                    hi_byte_next = req.wdata[15:8];
                    ans_next.rdata = DATA_RESET;
                    ans_next.low_discarded = 1'b0;
                    addr_next = mapped;
                    split_next = 1'b0;
                    if (req.kind == CYC_FETCH) begin
                        addr_next = {mapped[23:1], 1'b0};
                        hi_en_n_next = 1'b0;
                    end else if (is_word && !mapped[0]) begin
                        hi_en_n_next = 1'b0;
                        dout_next = req.wdata;
                    end else if (mapped[0]) begin
                        hi_en_n_next = 1'b0;
                        split_next = is_word;
                        dout_next = {req.wdata[7:0], req.wdata[7:0]};
                    end else begin
                        hi_en_n_next = 1'b1;
                        dout_next = req.wdata;
                    end
                end
            end
            ST_STATUS: begin
                // Write data lanes follow the address bit and upper enable
                oe_next[0] = wr_reg & ~addr_reg[0];
                oe_next[1] = wr_reg & ~hi_en_n_reg;
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (ready_seen) begin
                    oe_next = 2'b00;
                    // Gather read bytes into the internal halves
                    if (!wr_reg) begin
                        if (odd_fetch_reg) begin
                            ans_next.rdata = {8'h00, lane_data[15:8]};
                            ans_next.low_discarded = 1'b1;
                        end else if (!addr_reg[0] && !hi_en_n_reg) begin
                            ans_next.rdata = lane_data;
                        end else if (addr_reg[0]) begin
                            ans_next.rdata = {8'h00, lane_data[15:8]};
                        end else if (second_reg) begin
                            ans_next.rdata[15:8] = lane_data[7:0];
                        end else begin
                            ans_next.rdata = {8'h00, lane_data[7:0]};
                        end
                    end
                    if (split_reg) begin
                        // Second half of an odd word: next byte, low lane
                        split_next = 1'b0;
                        second_next = 1'b1;
                        addr_next = addr_reg + ADDR_ONE;
                        hi_en_n_next = 1'b1;
                        dout_next = {hi_byte_reg, hi_byte_reg};
                        stat_next = cyc_stat_reg;
                        state_next = ST_STATUS;
                    end else begin
                        ans_next.done = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            addr_reg <= ADDR_RESET;
            hi_en_n_reg <= 1'b1;
            stat_reg <= STAT_PASSIVE;
            cyc_stat_reg <= STAT_PASSIVE;
            dout_reg <= DATA_RESET;
            oe_reg <= 2'b00;
            split_reg <= 1'b0;
            second_reg <= 1'b0;
            wr_reg <= 1'b0;
            odd_fetch_reg <= 1'b0;
            hi_byte_reg <= 8'h00;
            ack_cyc_reg <= 1'b0;
            ans_reg <= '0;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            hi_en_n_reg <= hi_en_n_next;
            stat_reg <= stat_next;
            cyc_stat_reg <= cyc_stat_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            split_reg <= split_next;
            second_reg <= second_next;
            wr_reg <= wr_next;
            odd_fetch_reg <= odd_fetch_next;
            hi_byte_reg <= hi_byte_next;
            ack_cyc_reg <= ack_cyc_next;
            ans_reg <= ans_next;
        end
    end

    assign addr_out = addr_reg;
    assign upper_lane_enable_n = hi_en_n_reg;
    assign stat_out = stat_reg;
    assign data_out = dout_reg;
    assign data_oe = oe_reg;
    assign ans = ans_reg;

    // ****************************************************************
    // Hardware interrupt requests and vectors
    // ****************************************************************
    logic nmi_prev_reg, nmi_prev_next;
    logic nmi_busy_reg, nmi_busy_next;
    logic nmi_saved_reg, nmi_saved_next;
    logic nmi_take_reg, nmi_take_next;
    logic [7:0] vec_reg, vec_next;
    logic [23:0] ptr_reg, ptr_next;
    logic nmi_rise, ack_done;

    assign nmi_rise = nmi_lvl & ~nmi_prev_reg;
    assign ack_done = ans_next.done & ack_cyc_reg;

    // A second NMI during service is held until the return; a new
    // edge in the return cycle still counts (set beats clear)
    always_comb begin
        nmi_prev_next = nmi_lvl;
        nmi_take_next = 1'b0;
        nmi_busy_next = nmi_busy_reg;
        nmi_saved_next = nmi_saved_reg;
        vec_next = vec_reg;
        if (iret_done) begin
            nmi_busy_next = 1'b0;
        end
        if (nmi_rise && nmi_busy_reg && !iret_done) begin
            nmi_saved_next = 1'b1;
        end else if ((nmi_rise || nmi_saved_reg) &&
                     (!nmi_busy_reg || iret_done)) begin
            nmi_take_next = 1'b1;
            nmi_busy_next = 1'b1;
            nmi_saved_next = 1'b0;
            vec_next = NMI_VECTOR;
        end else if (ack_done) begin
            vec_next = ans_next.rdata[7:0];
        end
        // Pointer table: 4-byte entries in real, 8-byte in protected
        ptr_next = protected_mode ? {13'h0000, vec_next, 3'h0}
                                  : {14'h0000, vec_next, 2'h0};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev_reg <= 1'b0;
            nmi_busy_reg <= 1'b0;
            nmi_saved_reg <= 1'b0;
            nmi_take_reg <= 1'b0;
            vec_reg <= 8'h00;
            ptr_reg <= ADDR_RESET;
        end else begin
            nmi_prev_reg <= nmi_prev_next;
            nmi_busy_reg <= nmi_busy_next;
            nmi_saved_reg <= nmi_saved_next;
            nmi_take_reg <= nmi_take_next;
            vec_reg <= vec_next;
            ptr_reg <= ptr_next;
        end
    end

    // Masked request is simply withheld; held off while NMI in service
    assign maskable_take = irq_lvl & int_enable & ~nmi_busy_reg;
    assign nmi_take = nmi_take_reg;
    assign int_vector = vec_reg;
    assign vector_ptr = ptr_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_odd_word_start;
        state_reg == ST_IDLE && req.valid && req.word &&
        req.kind == CYC_MEM_RD && addr_next[0];
    endsequence

    sequence s_odd_word_second;
        ##1 addr_reg[0] && !upper_lane_enable_n
        ##[2:1000] (state_reg == ST_STATUS && !addr_reg[0] &&
                    upper_lane_enable_n);
    endsequence

    a_status_first_half: assert property (
        state_reg == ST_STATUS |=> stat_reg == STAT_PASSIVE)
        else $error("status held past first state");
    a_no_dead_lane: assert property (
        state_reg != ST_IDLE |-> !(addr_out[0] && upper_lane_enable_n))
        else $error("no byte lane selected");
    a_io_top_low: assert property (
        (stat_reg == STAT_IO_RD || stat_reg == STAT_IO_WR)
        |-> addr_out[23:20] == 4'h0)
        else $error("io cycle with top address lines set");
    a_real_mode_1mb: assert property (
        !protected_mode && state_reg == ST_STATUS
        && $past(state_reg) == ST_IDLE |-> addr_out[23:20] == 4'h0)
        else $error("real mode address above 1 megabyte");
    a_fetch_even_word: assert property (
        stat_reg == STAT_FETCH |-> !addr_out[0] && !upper_lane_enable_n)
        else $error("prefetch not an even word");
    a_odd_word_split: assert property (
        s_odd_word_start |-> s_odd_word_second)
        else $error("odd word not split into two byte cycles");
    a_even_byte_lane: assert property (
        data_oe[0] && state_reg == ST_WAIT && upper_lane_enable_n
        |-> !data_oe[1] && !addr_out[0])
        else $error("even byte drives upper lane");
    a_odd_byte_lane: assert property (
        data_oe[1] && addr_out[0] |-> !data_oe[0] && !upper_lane_enable_n)
        else $error("odd byte drives lower lane");
    a_halt_bit_one: assert property (
        state_reg == ST_IDLE && req.valid && req.kind == CYC_HALT
        |=> stat_reg == STAT_HALT && addr_out[1])
        else $error("halt without address bit 1");
    a_nmi_vector_two: assert property (
        nmi_take |-> int_vector == NMI_VECTOR ##1 !nmi_take)
        else $error("nmi vector wrong or pulse too long");

endmodule

// file: design/cpulb_pkg.sv
// Purpose: Shared constants and types for the local bus lane steering block
// Assumes: 24-bit address, 16-bit data, one 100 MHz clock domain
// Notes:   Status codes are packed {code, mem_io, status_hi, status_lo}
package cpulb_pkg;

    // ****************************************************************
    // Widths and address limits
    // ****************************************************************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int VEC_W = 8;
    localparam int SYNC_STAGES = 3;
    localparam logic [23:0] REAL_ADDR_MASK = 24'h0f_ffff; // 1 megabyte
    localparam logic [23:0] PROT_ADDR_MASK = 24'hff_ffff; // 16 megabytes
    localparam logic [23:0] IO_ADDR_MASK = 24'h00_ffff;   // 64K ports
    localparam logic [23:0] HALT_ADDR = 24'h00_0002;      // Bit 1 set
    localparam logic [23:0] SHUTDOWN_ADDR = 24'h00_0000;  // Bit 1 clear
    localparam logic [23:0] ADDR_ONE = 24'h00_0001;
    localparam logic [7:0] NMI_VECTOR = 8'h02;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;

    // ****************************************************************
    // Cycle status encodings {code, mem_io, status_hi, status_lo}
    // ****************************************************************
    localparam logic [3:0] STAT_PASSIVE = 4'h3;
    localparam logic [3:0] STAT_MEM_RD = 4'h6;
    localparam logic [3:0] STAT_IO_RD = 4'h2;
    localparam logic [3:0] STAT_FETCH = 4'he;
    localparam logic [3:0] STAT_MEM_WR = 4'h5;
    localparam logic [3:0] STAT_IO_WR = 4'h1;
    localparam logic [3:0] STAT_INT_ACK = 4'h0;
    localparam logic [3:0] STAT_HALT = 4'h4;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        CYC_MEM_RD = 3'h0,
        CYC_IO_RD = 3'h1,
        CYC_FETCH = 3'h2,
        CYC_MEM_WR = 3'h3,
        CYC_IO_WR = 3'h4,
        CYC_INT_ACK = 3'h5,
        CYC_HALT = 3'h6,
        CYC_SHUTDOWN = 3'h7
    } cpulb_cyc_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STATUS = 3'b010,
        ST_WAIT = 3'b100
    } cpulb_state_t;

    typedef struct packed {
        logic code_or_int_ack_status;
        logic mem_or_io;
        logic cycle_status_hi;
        logic cycle_status_lo;
    } cpulb_stat_t;

    typedef struct packed {
        logic valid;
        cpulb_cyc_t kind;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cpulb_req_t;

    typedef struct packed {
        logic done;
        logic low_discarded;
        logic [15:0] rdata;
    } cpulb_ans_t;

endpackage

// file: tb/cpulb_bus_partner.sv
// Purpose: Memory and port model on the far side of the local bus
// Assumes: 256-word store indexed by address bits 8..1
// Notes:   Ready is held low for two cycles per bus cycle
`timescale 1ns/1ps
module cpulb_bus_partner
    import cpulb_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic [23:0] addr_out,
    input wire cpulb_stat_t stat_out,
    input wire logic [15:0] data_out,
    input wire logic [1:0] data_oe,
    output logic [15:0] data_in,
    output logic bus_ready_n
);
    logic [15:0] mem [0:255];
    logic [7:0] idx;
    int cnt;
    int w;

    // Preload a pattern the bench can predict
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {~i[7:0], i[7:0]};
        end
        cnt = 99;
        idx = 8'h00;
        bus_ready_n = 1'b1;
        data_in = 16'h0000;
    end

    always_comb w = slow ? 5 : 0;

    // A status code opens a cycle; released data toggles so no stale word
    always @(posedge clk) begin
        if (stat_out != STAT_PASSIVE) begin
            idx <= addr_out[8:1];
            cnt <= 0;
            bus_ready_n <= 1'b1;
            data_in <= ~data_in;
        end else if (cnt < 99) begin
            cnt <= cnt + 1;
            // Two cycles pass the agree filter; a longer pulse would
            // still look ready in the next wait state and end it early
            if (cnt >= w && cnt < w + 2) begin
                bus_ready_n <= 1'b0;
                data_in <= mem[idx];
                // Low lane is the even bank, high lane the odd bank
                if (data_oe[0]) mem[idx][7:0] <= data_out[7:0];
                if (data_oe[1]) mem[idx][15:8] <= data_out[15:8];
            end else begin
                bus_ready_n <= 1'b1;
                data_in <= ~data_in;
            end
        end
    end
endmodule

// file: tb/tb_cpulb_lane_steer.sv
// Purpose: Self-checking bench for the lane steering block
// Assumes: Partner model answers every bus cycle
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
module tb_cpulb_lane_steer;
    import cpulb_pkg::*;
    logic clk, rst_n, protected_mode, slow, nmi_pin, maskable_request;
    logic int_enable, iret_done, req_ready, upper_lane_enable_n;
    logic bus_ready_n, nmi_take, maskable_take, f_hi_n, l_hi_n, seen;
    logic [23:0] addr_out, vector_ptr, f_addr, l_addr;
    logic [15:0] data_out, data_in;
    logic [7:0] int_vector;
    logic [1:0] data_oe, f_oe;
    cpulb_req_t req;
    cpulb_ans_t ans;
    cpulb_stat_t stat_out, f_stat;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    cpulb_lane_steer i_cpulb_lane_steer(.clk(clk), .rst_n(rst_n),
        .protected_mode(protected_mode), .req(req), .req_ready(req_ready),
        .ans(ans), .addr_out(addr_out),
        .upper_lane_enable_n(upper_lane_enable_n), .stat_out(stat_out),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .bus_ready_n(bus_ready_n), .nmi_pin(nmi_pin),
        .maskable_request(maskable_request), .int_enable(int_enable),
        .iret_done(iret_done), .nmi_take(nmi_take),
        .maskable_take(maskable_take), .int_vector(int_vector),
        .vector_ptr(vector_ptr));
    cpulb_bus_partner i_cpulb_bus_partner(.clk(clk), .slow(slow),
        .addr_out(addr_out), .stat_out(stat_out), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .bus_ready_n(bus_ready_n));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] mw(input logic [23:0] a);
        return {~a[8:1], a[8:1]};
    endfunction

    task automatic chk(input string s, input logic [23:0] e,
                       input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One request; records first and last status cycle seen on the pins
    task automatic bus(input cpulb_cyc_t k, input logic w,
                       input logic [23:0] a, input logic [15:0] d);
        f_stat = STAT_PASSIVE;
        f_oe = 2'b00;
        while (req_ready !== 1'b1) @(negedge clk);
        req = '{1'b1, k, w, a, d};
        @(negedge clk);
        req.valid = 1'b0;
        chk("busy", 24'h0, req_ready);
        for (int n = 0; n < 80 && ans.done !== 1'b1; n++) begin
            if (stat_out !== STAT_PASSIVE) begin
                if (f_stat === STAT_PASSIVE) begin
                    f_stat = stat_out;
                    f_addr = addr_out;
                    f_hi_n = upper_lane_enable_n;
                end
                l_addr = addr_out;
                l_hi_n = upper_lane_enable_n;
            end
            f_oe = f_oe | data_oe;
            @(negedge clk);
        end
        chk("done", 1, ans.done);
    endtask

    task automatic wait_take();
        seen = 1'b0;
        repeat (12) begin
            if (nmi_take === 1'b1) seen = 1'b1;
            @(negedge clk);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk("idle stat", STAT_PASSIVE, stat_out);
        chk("idle ready", 24'h1, req_ready);
        chk("idle lanes", 3'h1, {data_oe, upper_lane_enable_n});
    endtask

    task automatic t_words();
        bus(CYC_MEM_RD, 1'b1, 24'h35_0010, 16'h0000);
        chk("word rd", mw(24'h10), ans.rdata);
        chk("mem rd code", STAT_MEM_RD, f_stat);
        chk("prot addr", 24'h35_0010, f_addr);
        chk("word upper", 24'h0, f_hi_n);
        protected_mode = 1'b0;
        bus(CYC_MEM_RD, 1'b1, 24'h35_0010, 16'h0000);
        chk("real addr", 24'h05_0010, f_addr);
        protected_mode = 1'b1;
    endtask

    task automatic t_bytes();
        bus(CYC_MEM_RD, 1'b0, 24'h21, 16'h0000);
        chk("odd byte", {8'h00, ~8'h10}, ans.rdata);
        chk("odd lanes", 24'h42, {f_addr[22:0], f_hi_n});
        bus(CYC_MEM_RD, 1'b0, 24'h20, 16'h0000);
        chk("even byte", 16'h0010, ans.rdata);
        chk("even upper", 24'h1, f_hi_n);
        bus(CYC_MEM_WR, 1'b0, 24'h31, 16'h00a5);
        chk("odd wr oe", 2'b10, f_oe);
        bus(CYC_MEM_WR, 1'b0, 24'h30, 16'h003c);
        chk("even wr oe", 2'b01, f_oe);
        bus(CYC_MEM_RD, 1'b1, 24'h30, 16'h0000);
        chk("steered", 16'ha53c, ans.rdata);
    endtask

    task automatic t_odd_word();
        slow = 1'b0;
        bus(CYC_MEM_WR, 1'b1, 24'h41, 16'hbeef);
        chk("mem wr code", STAT_MEM_WR, f_stat);
        chk("split 1st", 24'h82, {f_addr[22:0], f_hi_n});
        chk("split 2nd", 24'h85, {l_addr[22:0], l_hi_n});
        bus(CYC_MEM_RD, 1'b1, 24'h41, 16'h0000);
        chk("odd word", 16'hbeef, ans.rdata);
        bus(CYC_MEM_RD, 1'b1, 24'h40, 16'h0000);
        chk("hi lane", 16'hef20, ans.rdata);
        slow = 1'b1;
    endtask

    task automatic t_fetch();
        bus(CYC_FETCH, 1'b0, 24'h53, 16'h0000);
        chk("fetch code", STAT_FETCH, f_stat);
        chk("fetch addr", 24'ha4, {f_addr[22:0], f_hi_n});
        chk("fetch odd", {1'b1, 16'h00d6}, ans[16:0]);
        bus(CYC_FETCH, 1'b0, 24'h54, 16'h0000);
        chk("fetch even", {1'b0, mw(24'h54)}, ans[16:0]);
    endtask

    task automatic t_io();
        bus(CYC_IO_RD, 1'b1, 24'hf0_1234, 16'h0000);
        chk("io rd code", STAT_IO_RD, f_stat);
        chk("io addr", 24'h00_1234, f_addr);
        chk("io word", mw(24'h1234), ans.rdata);
        bus(CYC_IO_WR, 1'b0, 24'hff_0077, 16'h0066);
        chk("io wr code", STAT_IO_WR, f_stat);
        chk("io byte", {22'h00_0077, 2'b10}, {f_addr[21:0], f_oe});
        bus(CYC_HALT, 1'b0, 24'h12_3451, 16'h0000);
        chk("halt", 24'h40_0002, {f_stat, f_addr[19:0]});
        bus(CYC_SHUTDOWN, 1'b0, 24'h12_3452, 16'h0000);
        chk("shutdown", 24'h40_0000, {f_stat, f_addr[19:0]});
    endtask

    task automatic t_irq();
        maskable_request = 1'b1;
        repeat (6) @(negedge clk);
        chk("masked", 0, maskable_take);
        int_enable = 1'b1;
        repeat (6) @(negedge clk);
        chk("unmasked", 1, maskable_take);
        nmi_pin = 1'b1;
        wait_take();
        chk("nmi", 1, seen);
        chk("nmi vec", 24'h02_0010, {int_vector, vector_ptr[15:0]});
        chk("in service", 0, maskable_take);
        nmi_pin = 1'b0;
        repeat (5) @(negedge clk);
        nmi_pin = 1'b1;
        wait_take();
        chk("nmi held", 0, seen);
        iret_done = 1'b1;
        @(negedge clk);
        iret_done = 1'b0;
        wait_take();
        chk("nmi saved", 1, seen);
        bus(CYC_INT_ACK, 1'b0, 24'h12_3456, 16'h0000);
        chk("ack code", STAT_INT_ACK, f_stat);
        chk("ack vec", 24'h00_0000, {int_vector, vector_ptr[15:0]});
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        {rst_n, nmi_pin, maskable_request, int_enable, iret_done} = '0;
        protected_mode = 1'b1;
        slow = 1'b1;
        req = '0;
        repeat (8) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_words();
        t_bytes();
        t_odd_word();
        t_fetch();
        t_io();
        t_irq();
        wrap_up();
    end
endmodule
